// ===== hpw_defs.svh
// timing counts and field widths of the host-port write sequencer
`ifndef HPW_DEFS_SVH
`define HPW_DEFS_SVH

`define HPW_ADDR_W 24
`define HPW_DATA_W 16
`define HPW_CSSEL_W 4
`define HPW_CNT_W 6
`define HPW_ADDR_PARAM_W 4
`define HPW_SETUP_PARAM_W 4
`define HPW_STROBE_PARAM_W 4
`define HPW_HOLD_PARAM_W 6
`define HPW_RECOV_PARAM_W 4

// highest chip select that shares the wait input
`define HPW_WAIT_CS_MAX 4'h7
// strobe width 4 to 5 cycles
`define HPW_STROBE_MIN 6'h04
`define HPW_STROBE_MAX 6'h05
// data hold 4 to 36 cycles after strobe rise
`define HPW_HOLD_MIN 6'h04
`define HPW_HOLD_MAX 6'h24
// recovery 2 to 17 cycles
`define HPW_RECOV_MIN 6'h02
// extra setup cycle after ready drops
`define HPW_RDY_EXTRA 6'h01
`define HPW_CNT_ONE 6'h01
`define HPW_CNT_ZERO 6'h00

// synchroniser width and idle levels: ready low, wait high
`define HPW_SYNC_W 2
`define HPW_SYNC_RST 2'h2
`define HPW_SYNC_RDY 0
`define HPW_SYNC_WAIT 1

`endif

// ===== hpw_pkg.sv
// types of the host-port write sequencer
package hpw_pkg;

	// chip select bus mode
	typedef enum logic [1:0] {
		HPW_MODE_PLAIN,
		HPW_MODE_STROBE_A,
		HPW_MODE_STROBE_B,
		HPW_MODE_SPARE
	} hpw_mode_t;

	// write sequence phases
	typedef enum logic [2:0] {
		HPW_IDLE,
		HPW_ADDR,
		HPW_SETUP,
		HPW_STROBE,
		HPW_HOLD,
		HPW_RECOV
	} hpw_state_t;

endpackage : hpw_pkg

// ===== hpw_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module hpw_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	////////////////////////////////////////////////////////////////////////
	// one filter per bit
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			// shift chain, first stage only feeds second
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					stage1[gi] <= RST_VAL[gi];
					stage2[gi] <= RST_VAL[gi];
					stage3[gi] <= RST_VAL[gi];
				end else if (ce) begin
					stage1[gi] <= pin_in[gi];
					stage2[gi] <= stage1[gi];
					stage3[gi] <= stage2[gi];
				end
			end

			// output moves once stages two and three agree
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					pin_out[gi] <= RST_VAL[gi];
				end else if (ce && (stage2[gi] == stage3[gi])) begin
					pin_out[gi] <= stage3[gi];
				end
			end
		end
	endgenerate

endmodule : hpw_sync

`default_nettype wire

// ===== hpw_write_seq.sv
// host-port write cycle sequencer of the expansion bus controller
// Operation
// RL1: address driven with chip select, held
// RL2: programmed delay from select to strobe
// RL3: data strobe active four to five cycles
// RL4: write data valid before strobe rise
// RL5: data held 4 to 36 cycles after
// RL6: recovery of 2 to 17 cycles between
// RL7: software sets setup parameter at least two
// RL8: software sets strobe parameter at least one
// RL9: ready drop keeps setup one more clock
// RL10: shared wait on selects 0-7, strobe modes
// RL11: wait lengthens data access for slow devices
// RL12: wait ignored on synchronous first-mode writes
// RL13: wait active low, holds current phase
`timescale 1ns/1ns
`default_nettype none

`include "hpw_defs.svh"

module hpw_write_seq
	import hpw_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wr_req,
	input wire logic [`HPW_ADDR_W-1:0] wr_addr,
	input wire logic [`HPW_DATA_W-1:0] wr_data,
	input wire logic [`HPW_CSSEL_W-1:0] wr_cs_sel,
	input wire logic [1:0] cs_mode,
	input wire logic sync_write,
	input wire logic sixteen_bit_host_port_mode,
	input wire logic [`HPW_ADDR_PARAM_W-1:0] addr_phase_param,
	input wire logic [`HPW_SETUP_PARAM_W-1:0] setup_phase_param,
	input wire logic [`HPW_STROBE_PARAM_W-1:0] strobe_phase_param,
	input wire logic [`HPW_HOLD_PARAM_W-1:0] hold_phase_param,
	input wire logic [`HPW_RECOV_PARAM_W-1:0] recov_phase_param,
	input wire logic host_ready_ind,
	input wire logic ext_slow_wait_n,
	output logic chip_sel_n,
	output logic [`HPW_CSSEL_W-1:0] cs_index,
	output logic [`HPW_ADDR_W-1:0] addr_out,
	output logic [`HPW_DATA_W-1:0] data_out,
	output logic data_oe_n,
	output logic host_data_strobe_n,
	output logic busy,
	output logic wait_stretch,
	output logic wr_done
);

	hpw_state_t state;
	hpw_state_t next_state;
	logic [`HPW_CNT_W-1:0] cnt;
	logic [`HPW_CNT_W-1:0] next_cnt;
	logic [`HPW_SYNC_W-1:0] sync_out;
	logic rdy_s;
	logic wait_s_n;
	logic rdy_seen;
	logic rdy_extra;
	logic wait_hold;
	logic access_on;
	// one-cycle take strobe, shared by the capture registers
	logic take;
	logic [`HPW_CSSEL_W-1:0] cur_cs;
	hpw_mode_t cur_mode;
	logic cur_sync;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers for ready and wait
	hpw_sync #(
		.WIDTH(`HPW_SYNC_W),
		.RST_VAL(`HPW_SYNC_RST)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.pin_in({ext_slow_wait_n, host_ready_ind}),
		.pin_out(sync_out)
	);

	assign rdy_s = sync_out[`HPW_SYNC_RDY];
	assign wait_s_n = sync_out[`HPW_SYNC_WAIT];

	////////////////////////////////////////////////////////////////////////
	// phase length decoding, counts are loaded as length minus one
	function automatic logic [`HPW_CNT_W-1:0] phase_len(input hpw_state_t ph,
			input logic [`HPW_ADDR_PARAM_W-1:0] a_p,
			input logic [`HPW_SETUP_PARAM_W-1:0] s_p,
			input logic [`HPW_STROBE_PARAM_W-1:0] t_p,
			input logic [`HPW_HOLD_PARAM_W-1:0] h_p,
			input logic [`HPW_RECOV_PARAM_W-1:0] r_p);
		logic [`HPW_CNT_W-1:0] len;
		len = `HPW_CNT_ZERO;
		case (ph)
			HPW_ADDR: len = `HPW_CNT_W'(a_p); // RL1
			HPW_SETUP: len = `HPW_CNT_W'(s_p); // RL2
			HPW_STROBE: begin
				// clamp width into four to five cycles
				len = `HPW_STROBE_MIN + `HPW_CNT_W'(t_p); // RL3
				if (len > `HPW_STROBE_MAX) begin
					len = `HPW_STROBE_MAX;
				end
				len = len - `HPW_CNT_ONE;
			end
			HPW_HOLD: begin
				// clamp the parameter first, a plain sum would wrap the six-bit count
				if (h_p > (`HPW_HOLD_MAX - `HPW_HOLD_MIN)) begin
					len = `HPW_HOLD_MAX; // RL5
				end else begin
					len = `HPW_HOLD_MIN + h_p; // RL5
				end
				len = len - `HPW_CNT_ONE;
			end
			HPW_RECOV: len = `HPW_RECOV_MIN + `HPW_CNT_W'(r_p) - `HPW_CNT_ONE; // RL6
			default: len = `HPW_CNT_ZERO;
		endcase
		return len;
	endfunction : phase_len

	// phases in which select is low and write data is driven
	function automatic logic in_access_phase(input hpw_state_t ph);
		logic hit;
		hit = 1'b0;
		case (ph)
			HPW_ADDR, HPW_SETUP, HPW_STROBE, HPW_HOLD: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : in_access_phase

	// either of the two strobe-style chip select modes
	function automatic logic is_strobe_mode(input hpw_mode_t md);
		logic hit;
		hit = 1'b0;
		case (md)
			HPW_MODE_STROBE_A, HPW_MODE_STROBE_B: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : is_strobe_mode

	////////////////////////////////////////////////////////////////////////
	// wait qualification
	// any phase with select low
	assign access_on = in_access_phase(state);
	// request accepted at this edge
	assign take = ce && (state == HPW_IDLE) && (next_state == HPW_ADDR);
	// only selects 0-7 in a strobe mode, never a synchronous first-mode write
	assign wait_hold = (cur_cs <= `HPW_WAIT_CS_MAX) && // RL10
		is_strobe_mode(cur_mode) && // RL10
		!((cur_mode == HPW_MODE_STROBE_A) && cur_sync) && // RL12
		!wait_s_n && // RL13
		((state == HPW_SETUP) || (state == HPW_STROBE)); // RL11

	////////////////////////////////////////////////////////////////////////
	// next phase and count
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			HPW_IDLE: begin
				if (wr_req && sixteen_bit_host_port_mode) begin
					next_state = HPW_ADDR; // RL1
					next_cnt = phase_len(HPW_ADDR, addr_phase_param, setup_phase_param,
						strobe_phase_param, hold_phase_param, recov_phase_param);
				end
			end
			HPW_ADDR, HPW_SETUP, HPW_STROBE, HPW_HOLD, HPW_RECOV: begin
				if (wait_hold) begin
					next_cnt = cnt; // RL13
				end else if (state == HPW_SETUP && (rdy_s || rdy_extra)) begin
					next_cnt = cnt; // RL9
				end else if (cnt != `HPW_CNT_ZERO) begin
					next_cnt = cnt - `HPW_CNT_ONE;
				end else begin
					case (state)
						HPW_ADDR: next_state = HPW_SETUP; // RL2
						HPW_SETUP: next_state = HPW_STROBE;
						HPW_STROBE: next_state = HPW_HOLD; // RL4
						HPW_HOLD: next_state = HPW_RECOV;
						default: next_state = HPW_IDLE; // RL6
					endcase
					next_cnt = phase_len(next_state, addr_phase_param, setup_phase_param,
						strobe_phase_param, hold_phase_param, recov_phase_param);
				end
			end
			default: begin
				next_state = HPW_IDLE;
				next_cnt = `HPW_CNT_ZERO;
			end
		endcase
	end

	// phase register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= HPW_IDLE;
			cnt <= `HPW_CNT_ZERO;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ready tracking: after a drop, setup runs one more clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdy_seen <= 1'b0;
			rdy_extra <= 1'b0;
		end else if (ce) begin
			if (state != HPW_SETUP) begin
				rdy_seen <= 1'b0;
				rdy_extra <= 1'b0;
			end else if (rdy_s) begin
				rdy_seen <= 1'b1;
				rdy_extra <= 1'b0;
			end else if (rdy_seen) begin
				rdy_seen <= 1'b0;
				rdy_extra <= 1'b1; // RL9
			end else begin
				rdy_extra <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// access descriptor, captured with the request and kept for the wait decision
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cur_cs <= '0;
			cur_mode <= HPW_MODE_PLAIN;
			cur_sync <= 1'b0;
		end else if (take) begin
			cur_cs <= wr_cs_sel;
			cur_mode <= hpw_mode_t'(cs_mode);
			cur_sync <= sync_write;
		end
	end

	// address and data, launched with chip select, held until the next request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_out <= '0;
			data_out <= '0;
		end else if (take) begin
			addr_out <= wr_addr; // RL1
			data_out <= wr_data; // RL4
		end
	end

	assign cs_index = cur_cs;

	////////////////////////////////////////////////////////////////////////
	// bus pin levels, all but the stretch flag registered from the next phase so they move with it
	// select and data enable, low from address through hold
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chip_sel_n <= 1'b1;
			data_oe_n <= 1'b1;
		end else if (ce) begin
			chip_sel_n <= !in_access_phase(next_state); // RL1
			data_oe_n <= !in_access_phase(next_state); // RL5
		end
	end

	// data strobe, low for the strobe phase only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			host_data_strobe_n <= 1'b1;
		end else if (ce) begin
			host_data_strobe_n <= !(next_state == HPW_STROBE); // RL3
		end
	end

	// busy from capture to the end of recovery, requests refused meanwhile
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
		end else if (ce) begin
			busy <= (next_state != HPW_IDLE); // RL6
		end
	end

	// stretch flag, high while the wait input freezes a data phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_stretch <= 1'b0;
		end else if (ce) begin
			wait_stretch <= wait_hold && access_on; // RL11
		end
	end

	// completion pulse, in the first recovery cycle as select goes high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_done <= 1'b0;
		end else if (ce) begin
			wr_done <= (state == HPW_HOLD) && (next_state == HPW_RECOV);
		end
	end

endmodule : hpw_write_seq

`default_nettype wire

// ===== hpw_write_seq_props.sv
// timing checker of the host-port write sequencer
`timescale 1ns/1ns
`default_nettype none

module hpw_write_seq_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] cs_mode,
	input wire logic sync_write,
	input wire logic host_ready_ind,
	input wire logic chip_sel_n,
	input wire logic [3:0] cs_index,
	input wire logic [23:0] addr_out,
	input wire logic [15:0] data_out,
	input wire logic data_oe_n,
	input wire logic host_data_strobe_n,
	input wire logic busy,
	input wire logic wait_stretch,
	input wire logic wr_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [5:0] n;
	logic f;
	// strobe low cycles, and whether wait stretched them
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			n <= 6'h00;
			f <= 1'b0;
		end else if (host_data_strobe_n) begin
			n <= 6'h00;
			f <= 1'b0;
		end else begin
			n <= n + 6'h01;
			f <= f | wait_stretch;
		end
	end
	////////////////////////////////////////////////////////////
	AST_ADDR_HELD: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(addr_out))
		else $error("address moved during access");
	AST_STRB_DELAY: assert property ($fell(chip_sel_n) |-> host_data_strobe_n [*3])
		else $error("strobe too early");
	AST_STRB_W: assert property ($rose(host_data_strobe_n) && !f |-> n inside {6'h04, 6'h05})
		else $error("strobe width");
	AST_DATA_SETUP: assert property (!host_data_strobe_n |-> !data_oe_n && $stable(data_out))
		else $error("data not valid under strobe");
	AST_DATA_HOLD: assert property ($rose(host_data_strobe_n) |-> (!data_oe_n && $stable(data_out)) [*4])
		else $error("data hold short");
	AST_DONE: assert property (wr_done |-> $rose(chip_sel_n))
		else $error("done not at hold end");
	AST_RECOV: assert property ($rose(chip_sel_n) |-> (chip_sel_n && busy) [*2])
		else $error("recovery short");
	AST_READY: assert property ($fell(host_ready_ind) && !chip_sel_n && host_data_strobe_n
		|-> host_data_strobe_n [*4])
		else $error("setup left too soon");
	AST_WAIT_CS: assert property (wait_stretch |-> cs_index <= 4'h7 && cs_mode inside {2'h1, 2'h2})
		else $error("wait honoured outside its selects");
	AST_WAIT_SYNC: assert property (wait_stretch |-> !(cs_mode == 2'h1 && sync_write))
		else $error("wait honoured on synchronous write");
	AST_WAIT_HOLD: assert property (wait_stretch && $past(wait_stretch) |-> $stable(host_data_strobe_n))
		else $error("phase moved under wait");
endmodule : hpw_write_seq_chk

bind hpw_write_seq hpw_write_seq_chk i_chk (.clk, .nrst, .cs_mode, .sync_write, .host_ready_ind, .chip_sel_n,
	.cs_index, .addr_out, .data_out, .data_oe_n, .host_data_strobe_n, .busy, .wait_stretch, .wr_done);

`default_nettype wire

// ===== hpw_peer.sv
// model of the sixteen-bit host port peripheral
`timescale 1ns/1ns
`default_nettype none

module hpw_peer (
	input wire logic clk,
	input wire logic nrst,
	input wire logic chip_sel_n,
	input wire logic host_data_strobe_n,
	input wire logic [3:0] rdy_len,
	input wire logic [3:0] wait_len,
	output logic host_ready_ind,
	output logic ext_slow_wait_n
);
	logic [3:0] rc;
	logic [3:0] wc;
	logic cs_d;
	logic st_d;
	// ready and wait both start when select falls, wait ends when its count runs out or once the strobe closes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rc <= 4'h0;
			wc <= 4'h0;
			cs_d <= 1'b1;
			st_d <= 1'b1;
		end else begin
			cs_d <= chip_sel_n;
			st_d <= host_data_strobe_n;
			rc <= (cs_d && !chip_sel_n) ? rdy_len : (rc != 4'h0) ? rc - 4'h1 : 4'h0;
			wc <= (cs_d && !chip_sel_n) ? wait_len : (wc == 4'h0 || (!st_d && host_data_strobe_n)) ? 4'h0 : wc - 4'h1;
		end
	end
	assign host_ready_ind = rc != 4'h0;
	assign ext_slow_wait_n = wc == 4'h0; // pulled up when idle
endmodule : hpw_peer

`default_nettype wire

// ===== test_host_port_write_wait_timing.sv
// testbench of the host-port write sequencer
`timescale 1ns/1ns
`default_nettype none

module test_host_port_write_wait_timing;
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr_req = 1'b0, sync_write = 1'b0, sixteen_bit_host_port_mode = 1'b1;
	logic [23:0] wr_addr = 24'h0, addr_out;
	logic [15:0] wr_data = 16'h0, data_out;
	logic [3:0] wr_cs_sel = 4'h0, cs_index, addr_phase_param = 4'h0, setup_phase_param = 4'h2;
	logic [3:0] strobe_phase_param = 4'h1, recov_phase_param = 4'h0, rdy_len = 4'h0, wait_len = 4'h0;
	logic [5:0] hold_phase_param = 6'h00;
	logic [1:0] cs_mode = 2'h1;
	logic host_ready_ind, ext_slow_wait_n, chip_sel_n, data_oe_n, host_data_strobe_n, busy, wait_stretch, wr_done;
	int fails = 0, n_compared = 0, cyc = 0, ncs, nst, nrc, nd, nws;

	always #2 clk = ~clk;

	hpw_write_seq i_dut (.clk, .nrst, .ce, .wr_req, .wr_addr, .wr_data, .wr_cs_sel, .cs_mode, .sync_write,
		.sixteen_bit_host_port_mode, .addr_phase_param, .setup_phase_param, .strobe_phase_param,
		.hold_phase_param, .recov_phase_param, .host_ready_ind, .ext_slow_wait_n, .chip_sel_n, .cs_index,
		.addr_out, .data_out, .data_oe_n, .host_data_strobe_n, .busy, .wait_stretch, .wr_done);
	hpw_peer i_peer (.clk, .nrst, .chip_sel_n, .host_data_strobe_n, .rdy_len, .wait_len, .host_ready_ind,
		.ext_slow_wait_n);

	////////////////////////////////////////////////////////////
	// phase length counters and timeout
	always @(posedge clk) begin
		ncs += !chip_sel_n;
		nst += !host_data_strobe_n;
		nrc += chip_sel_n && busy;
		nd += wr_done;
		nws += wait_stretch;
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	task end_of_test;
		if (fails == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	task chk(input bit ok);
		n_compared++;
		if (!ok) begin
			fails++;
			$display("[FAIL] %0t phase or value mismatch", $time);
		end
	endtask : chk

	// one write; lc/lw expect a stretched access or strobe
	task automatic wr(input logic [5:0] h, input logic [3:0] r, input bit lc, input bit lw);
		int e;
		e = addr_phase_param + setup_phase_param + 7 + ((h > 6'h20) ? 36 : h + 4);
		@(negedge clk);
		hold_phase_param = h;
		recov_phase_param = r;
		wr_addr = wr_addr + 24'h10203;
		wr_data = wr_data + 16'h1357;
		ncs = 0;
		nst = 0;
		nrc = 0;
		nd = 0;
		nws = 0;
		wr_req = 1'b1;
		repeat (2) @(negedge clk);
		wr_req = 1'b0;
		for (int i = 0; i < 300 && busy; i++) @(negedge clk);
		chk(lc ? ncs > e : ncs == e);
		chk(lw ? nst > 5 : nst == 5);
		chk(nrc == r + 2);
		chk(nd == 1);
		chk(lw ? nws > 0 : nws == 0);
		chk(addr_out === wr_addr && data_out === wr_data && cs_index === wr_cs_sel);
	endtask : wr

	////////////////////////////////////////////////////////////
	task t_timing;
		chk(chip_sel_n === 1'b1 && host_data_strobe_n === 1'b1 && busy === 1'b0 && data_oe_n === 1'b1);
		wr(6'h00, 4'h0, 0, 0);
		wr(6'h20, 4'hF, 0, 0);
		setup_phase_param = 4'h4;
		strobe_phase_param = 4'h2;
		wr(6'h3F, 4'h3, 0, 0);
	endtask : t_timing

	task t_ready;
		addr_phase_param = 4'h3;
		rdy_len = 4'h6;
		wr(6'h01, 4'h1, 1, 0);
		rdy_len = 4'h0;
		addr_phase_param = 4'h0;
		setup_phase_param = 4'h2;
	endtask : t_ready

	task t_wait;
		logic [1:0] md [6] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h2};
		logic [3:0] cs [6] = '{4'h3, 4'h3, 4'h7, 4'h0, 4'h2, 4'h8};
		logic [5:0] hon = 6'h05;
		wait_len = 4'h6;
		for (int k = 0; k < 6; k++) begin
			cs_mode = md[k];
			wr_cs_sel = cs[k];
			sync_write = k == 1;
			wr(6'h02, 4'h0, hon[k], hon[k]);
		end
		wait_len = 4'h0;
	endtask : t_wait

	task t_refuse;
		@(negedge clk);
		sixteen_bit_host_port_mode = 1'b0;
		wr_req = 1'b1;
		repeat (4) @(negedge clk);
		chk(busy === 1'b0 && chip_sel_n === 1'b1);
		sixteen_bit_host_port_mode = 1'b1;
		ce = 1'b0;
		repeat (4) @(negedge clk);
		chk(busy === 1'b0 && chip_sel_n === 1'b1 && wr_done === 1'b0);
		wr_req = 1'b0;
		ce = 1'b1;
	endtask : t_refuse

	initial begin
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		t_timing();
		t_ready();
		t_wait();
		t_refuse();
		end_of_test();
	end
endmodule : test_host_port_write_wait_timing

`default_nettype wire
